//--- logic/fwsr_top.sv
`timescale 1ns/10ps
module fwsr_top import fwsr_pkg::*; (
    // clock, reset, enable
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    // register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // interrupt
    output logic irq_out,
    // flash pins
    output logic [18:0] flash_addr_out,
    output logic flash_ce_n_out,
    output logic flash_oe_n_out,
    output logic flash_we_n_out,
    input wire logic [7:0] flash_dq_in,
    output logic [7:0] flash_dq_out,
    output logic flash_dq_oe_n_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        fwsr_state_t st;
        logic issued;
        logic req;
        logic wr;
        logic [18:0] caddr;
        logic [7:0] wdata;
        logic [7:0] first;
        logic [7:0] last;
        logic [18:0] addr;
        logic busy;
        logic ok;
        logic fail;
        logic stopped;
        logic act_tgl;
        logic sec_tgl;
        logic win;
        logic tmo;
        logic poll_bit;
        logic stop_req;
        logic [2:0] ist;
        logic [2:0] imsk;
        logic [31:0] rdata;
        logic irq;
    } fwsr_regs_t;

    localparam fwsr_regs_t REGS_RST = '{
        st: S_IDLE,
        issued: 1'b0,
        req: 1'b0,
        wr: 1'b0,
        caddr: ADDR_RST,
        wdata: 8'h00,
        first: 8'h00,
        last: 8'h00,
        addr: ADDR_RST,
        busy: 1'b0,
        ok: 1'b0,
        fail: 1'b0,
        stopped: 1'b0,
        act_tgl: 1'b0,
        sec_tgl: 1'b0,
        win: 1'b0,
        tmo: 1'b0,
        poll_bit: 1'b0,
        stop_req: 1'b0,
        ist: INT_RST,
        imsk: INT_RST,
        rdata: 32'h00000000,
        irq: 1'b0
    };

    fwsr_regs_t r;
    fwsr_regs_t n;

    fwsr_cyc_if cyc ();

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic toggled(input logic [7:0] a, input logic [7:0] b, input int pos);
        toggled = a[pos] ^ b[pos];
    endfunction

    function automatic logic [31:0] status_word(input fwsr_regs_t s);
        status_word = {24'h000000, s.poll_bit, s.tmo, s.win, s.sec_tgl,
                       s.act_tgl, s.stopped, s.fail, s.ok} | {31'h00000000, 1'b0};
        status_word[8] = s.busy;
    endfunction

    // ------------------------------------------------------------
    // sequencer and registers
    // ------------------------------------------------------------
    always_comb begin
        logic [2:0] ev;
        logic [2:0] clr;
        logic go;
        logic [7:0] rb;
        ev = 3'h0;
        clr = 3'h0;
        go = 1'b0;
        rb = cyc.rdata;
        n = r;
        n.req = 1'b0;
        n.rdata = 32'h00000000;

        // register writes
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                REG_CTRL: begin
                    if (reg_wdata_in[CTRL_STOP] && r.busy) begin
                        n.stop_req = 1'b1;
                    end
                    go = 1'b1;
                end
                REG_ADDR: begin
                    n.addr = reg_wdata_in[18:0];
                end
                REG_INT: begin
                    clr = reg_wdata_in[2:0];
                end
                REG_MASK: begin
                    n.imsk = reg_wdata_in[2:0];
                end
                default: begin
                end
            endcase
        end

        // register reads, answered in the following cycle
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                REG_CTRL: n.rdata = 32'h00000000;
                REG_ADDR: n.rdata = {13'h0000, r.addr};
                REG_STAT: n.rdata = status_word(r);
                REG_BYTE: n.rdata = {24'h000000, r.last};
                REG_INT: n.rdata = {29'h00000000, r.ist};
                REG_MASK: n.rdata = {29'h00000000, r.imsk};
                default: n.rdata = 32'h00000000;
            endcase
        end

        // issue one bus cycle per state visit
        if (r.st != S_IDLE && !r.issued) begin
            n.issued = 1'b1;
            n.req = 1'b1;
            if (r.st == S_RST) begin
                n.wr = 1'b1;
                n.caddr = RST_CMD_ADDR;
                n.wdata = RST_CMD_DATA;
            end else begin
                n.wr = 1'b0;
                // status reads use the address software placed in a selected sector
                n.caddr = r.addr;
                n.wdata = 8'h00;
            end
        end

        // watch the window timer bit on every completed read
        if (cyc.done && !r.wr) begin
            n.last = rb;
            n.tmo = rb[DQ_TMO];
            n.poll_bit = rb[DQ_POLL];
            n.win = rb[DQ_WIN];
            if (rb[DQ_WIN] && !r.win) begin
                ev[INT_WIN] = 1'b1;
            end
        end

        unique case (r.st)
            S_IDLE: begin
                if (go && reg_wdata_in[CTRL_RESET]) begin
                    n.st = S_RST;
                    n.busy = 1'b1;
                    n.issued = 1'b0;
                end else if (go && reg_wdata_in[CTRL_START]) begin
                    // every start begins with a fresh double read
                    n.st = S_RD1;
                    n.busy = 1'b1;
                    n.ok = 1'b0;
                    n.fail = 1'b0;
                    n.stopped = 1'b0;
                    n.stop_req = 1'b0;
                    n.issued = 1'b0;
                end else if (go && reg_wdata_in[CTRL_PEEK]) begin
                    n.st = S_ONE;
                    n.busy = 1'b1;
                    n.issued = 1'b0;
                end
            end
            S_RD1: begin
                if (cyc.done) begin
                    n.first = rb;
                    n.st = S_RD2;
                    n.issued = 1'b0;
                end
            end
            S_RD2: begin
                if (cyc.done) begin
                    n.issued = 1'b0;
                    // both toggle bits are reported; completion follows the activity bit
                    n.act_tgl = toggled(r.first, rb, DQ_ACT);
                    n.sec_tgl = toggled(r.first, rb, DQ_SEC);
                    if (!toggled(r.first, rb, DQ_ACT)) begin
                        n.st = S_IDLE;
                        n.busy = 1'b0;
                        n.ok = 1'b1;
                        ev[INT_DONE] = 1'b1;
                    end else if (rb[DQ_TMO]) begin
                        // toggling may have stopped just as the fail bit rose
                        n.st = S_RD3;
                    end else if (r.stop_req) begin
                        // abandoned here; status is stale until the next start
                        n.st = S_IDLE;
                        n.busy = 1'b0;
                        n.stopped = 1'b1;
                        n.stop_req = 1'b0;
                    end else begin
                        n.st = S_RD1;
                    end
                end
            end
            S_RD3: begin
                if (cyc.done) begin
                    n.first = rb;
                    n.st = S_RD4;
                    n.issued = 1'b0;
                end
            end
            S_RD4: begin
                if (cyc.done) begin
                    n.issued = 1'b0;
                    n.act_tgl = toggled(r.first, rb, DQ_ACT);
                    n.sec_tgl = toggled(r.first, rb, DQ_SEC);
                    if (!toggled(r.first, rb, DQ_ACT)) begin
                        n.st = S_IDLE;
                        n.busy = 1'b0;
                        n.ok = 1'b1;
                        ev[INT_DONE] = 1'b1;
                    end else begin
                        // failed operation leaves the flash in status mode until reset
                        n.st = S_RST;
                        n.fail = 1'b1;
                    end
                end
            end
            S_RST: begin
                if (cyc.done) begin
                    n.st = S_IDLE;
                    n.busy = 1'b0;
                    n.issued = 1'b0;
                    n.stop_req = 1'b0;
                    if (r.fail) begin
                        ev[INT_FAIL] = 1'b1;
                    end
                end
            end
            S_ONE: begin
                if (cyc.done) begin
                    n.st = S_IDLE;
                    n.busy = 1'b0;
                    n.issued = 1'b0;
                end
            end
            default: begin
                n.st = S_IDLE;
                n.busy = 1'b0;
                n.issued = 1'b0;
            end
        endcase

        // sticky events: a new event wins over a clear in the same cycle
        n.ist = (r.ist & ~clr) | ev;
        n.irq = |(n.ist & n.imsk);
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            r <= REGS_RST;
        end else if (ce_in) begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // bus cycle engine
    // ------------------------------------------------------------
    assign cyc.req = r.req;
    assign cyc.wr = r.wr;
    assign cyc.addr = r.caddr;
    assign cyc.wdata = r.wdata;

    fwsr_cycle fwsr_cycle_inst (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .ce_in(ce_in),
        .cyc(cyc),
        .dq_in(flash_dq_in),
        .addr_out(flash_addr_out),
        .ce_n_out(flash_ce_n_out),
        .oe_n_out(flash_oe_n_out),
        .we_n_out(flash_we_n_out),
        .dq_out(flash_dq_out),
        .dq_oe_n_out(flash_dq_oe_n_out)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata_out = r.rdata;
    assign irq_out = r.irq;

endmodule

//--- logic/fwsr_pkg.sv
package fwsr_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 4;
    localparam int T_RC_NS = 120;
    localparam int T_WP_NS = 50;
    localparam int T_RCV_NS = 20;
    localparam int RD_CYC = (T_RC_NS + CLK_NS - 1) / CLK_NS;
    localparam int WR_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RCV_CYC = (T_RCV_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [5:0] RD_CNT = 6'(RD_CYC);
    localparam logic [5:0] WR_CNT = 6'(WR_CYC);
    localparam logic [5:0] RCV_CNT = 6'(RCV_CYC);

    // ------------------------------------------------------------
    // flash side constants
    // ------------------------------------------------------------
    localparam logic [18:0] RST_CMD_ADDR = 19'h00000;
    localparam logic [7:0] RST_CMD_DATA = 8'hF0;
    localparam int DQ_POLL = 7;
    localparam int DQ_ACT = 6;
    localparam int DQ_TMO = 5;
    localparam int DQ_WIN = 3;
    localparam int DQ_SEC = 2;

    // ------------------------------------------------------------
    // own register map
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h1;
    localparam logic [3:0] REG_STAT = 4'h2;
    localparam logic [3:0] REG_BYTE = 4'h3;
    localparam logic [3:0] REG_INT = 4'h4;
    localparam logic [3:0] REG_MASK = 4'h5;
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_RESET = 2;
    localparam int CTRL_PEEK = 3;
    localparam logic [2:0] INT_RST = 3'h0;
    localparam int INT_DONE = 0;
    localparam int INT_FAIL = 1;
    localparam int INT_WIN = 2;
    localparam logic [18:0] ADDR_RST = 19'h00000;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_RD1 = 3'b001,
        S_RD2 = 3'b010,
        S_RD3 = 3'b011,
        S_RD4 = 3'b100,
        S_RST = 3'b101,
        S_ONE = 3'b110
    } fwsr_state_t;

    typedef enum logic [1:0] {
        C_IDLE = 2'b00,
        C_STRB = 2'b01,
        C_RCVR = 2'b10
    } fwsr_phase_t;

endpackage

//--- logic/fwsr_cyc_if.sv
`timescale 1ns/10ps
interface fwsr_cyc_if;
    logic req;
    logic wr;
    logic [18:0] addr;
    logic [7:0] wdata;
    logic done;
    logic [7:0] rdata;
    modport ctrl (output req, output wr, output addr, output wdata, input done, input rdata);
    modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

//--- logic/fwsr_cycle.sv
`timescale 1ns/10ps
module fwsr_cycle import fwsr_pkg::*; (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    // request side
    fwsr_cyc_if.eng cyc,
    // flash data input
    input wire logic [7:0] dq_in,
    // flash pins
    output logic [18:0] addr_out,
    output logic ce_n_out,
    output logic oe_n_out,
    output logic we_n_out,
    output logic [7:0] dq_out,
    output logic dq_oe_n_out
);

    typedef struct packed {
        fwsr_phase_t ph;
        logic [5:0] cnt;
        logic wr;
        logic done;
        logic [7:0] rdata;
        logic [18:0] addr;
        logic [7:0] dout;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic dq_oe_n;
    } fwsr_cyc_t;

    localparam fwsr_cyc_t CYC_RST = '{C_IDLE, 6'h00, 1'b0, 1'b0, 8'h00, 19'h00000, 8'h00,
                                      1'b1, 1'b1, 1'b1, 1'b1};

    fwsr_cyc_t r;
    fwsr_cyc_t n;

    always_comb begin
        n = r;
        n.done = 1'b0;
        unique case (r.ph)
            C_IDLE: begin
                if (cyc.req) begin
                    n.wr = cyc.wr;
                    n.addr = cyc.addr;
                    n.dout = cyc.wdata;
                    n.ce_n = 1'b0;
                    n.ph = C_STRB;
                    if (cyc.wr) begin
                        n.we_n = 1'b0;
                        n.dq_oe_n = 1'b0;
                        n.cnt = WR_CNT;
                    end else begin
                        // both strobes frame every read, since toggles advance only once both are low
                        n.oe_n = 1'b0;
                        n.cnt = RD_CNT;
                    end
                end
            end
            C_STRB: begin
                if (r.cnt == 6'h01) begin
                    if (!r.wr) begin
                        n.rdata = dq_in;
                    end
                    // strobes return high so the next read is a fresh cycle
                    n.ce_n = 1'b1;
                    n.oe_n = 1'b1;
                    n.we_n = 1'b1;
                    n.cnt = RCV_CNT;
                    n.ph = C_RCVR;
                end else begin
                    n.cnt = r.cnt - 6'h01;
                end
            end
            C_RCVR: begin
                if (r.cnt == 6'h01) begin
                    // data held past the write strobe rising edge
                    n.dq_oe_n = 1'b1;
                    n.done = 1'b1;
                    n.ph = C_IDLE;
                end else begin
                    n.cnt = r.cnt - 6'h01;
                end
            end
            default: begin
                n = CYC_RST;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            r <= CYC_RST;
        end else if (ce_in) begin
            r <= n;
        end
    end

    assign cyc.done = r.done;
    assign cyc.rdata = r.rdata;
    assign addr_out = r.addr;
    assign ce_n_out = r.ce_n;
    assign oe_n_out = r.oe_n;
    assign we_n_out = r.we_n;
    assign dq_out = r.dout;
    assign dq_oe_n_out = r.dq_oe_n;

endmodule

//--- bench/fwsr_top_assertions.sv
`timescale 1ns/10ps
module fwsr_top_assertions import fwsr_pkg::*; (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    // register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    // flash pins
    input wire logic [18:0] flash_addr_out,
    input wire logic flash_ce_n_out,
    input wire logic flash_oe_n_out,
    input wire logic flash_we_n_out,
    input wire logic [7:0] flash_dq_out,
    input wire logic flash_dq_oe_n_out
);
    typedef struct packed {
        logic [18:0] addr;
    } fwsr_chk_t;
    fwsr_chk_t s_r;
    fwsr_chk_t s_nxt;
    // --------
    // shadow of the poll address
    // --------
    always_comb begin
        s_nxt = s_r;
        if (ce_in && reg_wr_in && reg_addr_in == REG_ADDR) begin
            s_nxt.addr = reg_wdata_in[18:0];
        end
    end
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    // --------
    // properties
    // --------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    sequence s_rd_end;
        ##29 !flash_oe_n_out ##1 flash_oe_n_out;
    endsequence
    sequence s_recov;
        (flash_oe_n_out && flash_ce_n_out) [*5];
    endsequence
    a_read_timing: assert property ($fell(flash_oe_n_out) |-> s_rd_end ##0 s_recov)
        else $error("read strobe length or recovery wrong");
    a_write_timing: assert property ($fell(flash_we_n_out) |-> ##12 !flash_we_n_out
        ##1 (flash_we_n_out && !flash_dq_oe_n_out) ##5 flash_dq_oe_n_out)
        else $error("write strobe or data drive length wrong");
    a_reset_cmd: assert property ($fell(flash_we_n_out) |->
        flash_dq_out == RST_CMD_DATA && flash_addr_out == RST_CMD_ADDR)
        else $error("write is not the reset command");
    a_read_addr: assert property (!flash_oe_n_out |-> flash_addr_out == s_r.addr)
        else $error("status read at wrong address");
    a_no_contend: assert property (!flash_oe_n_out |-> flash_dq_oe_n_out && flash_we_n_out)
        else $error("data driven during read");
    a_strobe_select: assert property ((!flash_oe_n_out || !flash_we_n_out) |-> !flash_ce_n_out)
        else $error("strobe without chip select");
    a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
        else $error("read data outside its cycle");
    a_addr_hold: assert property (!flash_oe_n_out && !$fell(flash_oe_n_out) |-> $stable(flash_addr_out))
        else $error("address moved in a read");
endmodule
bind fwsr_top fwsr_top_assertions fwsr_top_assertions_inst (.clk_in(clk_in), .reset_in(reset_in),
    .ce_in(ce_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .flash_addr_out(flash_addr_out),
    .flash_ce_n_out(flash_ce_n_out), .flash_oe_n_out(flash_oe_n_out), .flash_we_n_out(flash_we_n_out),
    .flash_dq_out(flash_dq_out), .flash_dq_oe_n_out(flash_dq_oe_n_out));

//--- bench/fwsr_flash_model.sv
`timescale 1ns/10ps
module fwsr_flash_model import fwsr_pkg::*; #(
    parameter int WIN_CYC = 300,
    parameter logic [2:0] SEL_SECTOR = 3'h4,
    parameter logic [7:0] ARRAY_BYTE = 8'h00
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // scenario control
    input wire logic start_in,
    input wire logic [7:0] toggles_in,
    input wire logic tmo_in,
    // flash pins
    input wire logic [18:0] addr_in,
    input wire logic ce_n_in,
    input wire logic oe_n_in,
    input wire logic we_n_in,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out,
    // counters
    output logic [7:0] reads_out,
    output logic [7:0] resets_out
);
    typedef struct packed {
        logic busy;
        logic tmo;
        logic act;
        logic sec;
        logic fin;
        logic rd_q;
        logic wr_q;
        logic [7:0] left;
        logic [15:0] win;
        logic [7:0] last;
        logic [7:0] reads;
        logic [7:0] resets;
    } fwsr_flash_t;
    fwsr_flash_t s_r;
    fwsr_flash_t s_nxt;
    logic rd;
    logic wr;
    logic win_bit;
    logic [7:0] stat;
    assign rd = !ce_n_in && !oe_n_in;
    assign wr = !ce_n_in && !we_n_in;
    assign win_bit = s_r.win >= 16'(WIN_CYC);
    // status only while busy, the array comes back afterwards
    assign stat = s_r.busy ? {1'b0, s_r.act, s_r.tmo, 1'b0, win_bit, s_r.sec, 2'b00} : ARRAY_BYTE;
    // a released bus shows the inverse of the last byte, never a stale copy
    assign dq_out = rd ? stat : ~s_r.last;
    assign reads_out = s_r.reads;
    assign resets_out = s_r.resets;
    always_comb begin
        s_nxt = s_r;
        s_nxt.rd_q = rd;
        s_nxt.wr_q = wr;
        if (rd) begin
            s_nxt.last = stat;
        end
        if (s_r.busy && !win_bit) begin
            s_nxt.win = s_r.win + 16'h0001;
        end
        if (rd && !s_r.rd_q) begin
            s_nxt.reads = s_r.reads + 8'h01;
            if (s_r.busy && s_r.fin && s_r.left == 8'h00) begin
                s_nxt.busy = 1'b0;
            end else if (s_r.busy) begin
                s_nxt.act = !s_r.act;
                s_nxt.sec = s_r.sec ^ (addr_in[18:16] == SEL_SECTOR);
                s_nxt.left = s_r.left - 8'h01;
            end
        end
        // once the window has closed the reset command is ignored
        if (!wr && s_r.wr_q && dq_in == RST_CMD_DATA && !win_bit) begin
            s_nxt.busy = 1'b0;
            s_nxt.tmo = 1'b0;
            s_nxt.resets = s_r.resets + 8'h01;
        end
        if (start_in) begin
            s_nxt.busy = 1'b1;
            s_nxt.tmo = tmo_in;
            s_nxt.fin = toggles_in != 8'h00;
            s_nxt.left = toggles_in;
            s_nxt.win = 16'h0000;
        end
    end
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

//--- bench/fwsr_top_test.sv
`timescale 1ns/10ps
module fwsr_top_test import fwsr_pkg::*;;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic ce = 1'b1;
    logic [3:0] reg_addr_in = 4'h0;
    logic [31:0] reg_wdata_in = 32'h0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [31:0] reg_rdata_out;
    logic irq_out;
    logic [18:0] f_addr;
    logic f_ce_n;
    logic f_oe_n;
    logic f_we_n;
    logic [7:0] f_dq;
    logic f_dq_oe_n;
    logic [7:0] m_dq;
    logic [7:0] dq_bus;
    logic m_start = 1'b0;
    logic [7:0] m_tog = 8'h0;
    logic m_tmo = 1'b0;
    logic [7:0] m_reads;
    logic [7:0] m_resets;
    logic [7:0] rd0;
    logic [7:0] rs0;
    int n_errors = 0;
    int comparisons = 0;
    assign dq_bus = f_dq_oe_n ? m_dq : f_dq;
    fwsr_top fwsr_top_inst (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .irq_out(irq_out), .flash_addr_out(f_addr), .flash_ce_n_out(f_ce_n),
        .flash_oe_n_out(f_oe_n), .flash_we_n_out(f_we_n), .flash_dq_in(dq_bus), .flash_dq_out(f_dq),
        .flash_dq_oe_n_out(f_dq_oe_n));
    fwsr_flash_model fwsr_flash_model_inst (.clk_in(clk_in), .reset_in(reset_in), .start_in(m_start),
        .toggles_in(m_tog), .tmo_in(m_tmo), .addr_in(f_addr), .ce_n_in(f_ce_n), .oe_n_in(f_oe_n),
        .we_n_in(f_we_n), .dq_in(dq_bus), .dq_out(m_dq), .reads_out(m_reads), .resets_out(m_resets));
    initial begin
        forever #2 clk_in = ~clk_in;
    end
    // --------
    // helpers
    // --------
    task automatic conclude();
        if (n_errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1;
        d = reg_rdata_out;
    endtask
    task automatic wait_idle();
        logic [31:0] d;
        for (int i = 0; i < 400; i++) begin
            reg_rd(REG_STAT, d);
            if (d[8] === 1'b0) begin
                return;
            end
            repeat (8) @(posedge clk_in);
        end
        n_errors++;
        conclude();
    endtask
    // clears events, optionally arms the flash, issues a command, returns status
    task automatic run(input logic [7:0] n, input logic t, input logic [31:0] cmd, input logic go,
        output logic [31:0] st);
        reg_wr(REG_INT, 32'h7);
        rd0 = m_reads;
        rs0 = m_resets;
        if (go) begin
            @(posedge clk_in);
            m_start <= 1'b1;
            m_tog <= n;
            m_tmo <= t;
            @(posedge clk_in);
            m_start <= 1'b0;
        end
        reg_wr(REG_CTRL, cmd);
        wait_idle();
        reg_rd(REG_STAT, st);
    endtask
    // --------
    // scenarios
    // --------
    task automatic t_regs();
        logic [31:0] d;
        reg_rd(REG_STAT, d);
        check(d, 32'h0);
        reg_rd(REG_ADDR, d);
        check(d, 32'h0);
        reg_rd(REG_MASK, d);
        check(d, 32'h0);
        reg_wr(4'hF, 32'hFFFF_FFFF);
        reg_rd(4'hF, d);
        check(d, 32'h0);
        reg_wr(REG_ADDR, 32'hFFF4_0123);
        ce <= 1'b0;
        reg_wr(REG_ADDR, 32'h0);
        ce <= 1'b1;
        reg_rd(REG_ADDR, d);
        check(d, 32'h0004_0123);
        reg_wr(REG_MASK, 32'h7);
        #1;
        check(32'(irq_out), 32'h0);
    endtask
    task automatic t_done();
        logic [31:0] d;
        run(8'h02, 1'b0, 32'h1 << CTRL_START, 1'b1, d);
        check(32'(d[2:0]), 32'h1);
        check(32'(m_reads - rd0), 32'h4);
        reg_rd(REG_INT, d);
        check(32'(d[1:0]), 32'h1);
        check(32'(irq_out), 32'h1);
        reg_wr(REG_INT, 32'h7);
        @(posedge clk_in);
        #1;
        check(32'(irq_out), 32'h0);
    endtask
    task automatic t_late();
        logic [31:0] d;
        run(8'h02, 1'b1, 32'h1 << CTRL_START, 1'b1, d);
        check(32'(d[2:0]), 32'h1);
        check(32'(m_reads - rd0), 32'h4);
        check(32'(m_resets - rs0), 32'h0);
    endtask
    task automatic t_fail();
        logic [31:0] d;
        run(8'h00, 1'b1, 32'h1 << CTRL_START, 1'b1, d);
        check(32'(d[2:0]), 32'h2);
        check(32'(d[4:3]), 32'h3);
        check(32'(d[7:5]), 32'h2);
        check(32'(m_reads - rd0), 32'h4);
        check(32'(m_resets - rs0), 32'h1);
        reg_rd(REG_INT, d);
        check(32'(d[1:0]), 32'h2);
    endtask
    task automatic t_stop();
        logic [31:0] d;
        run(8'h00, 1'b0, 32'h0, 1'b1, d);
        reg_wr(REG_CTRL, 32'h1 << CTRL_START);
        repeat (60) @(posedge clk_in);
        reg_wr(REG_CTRL, 32'h1 << CTRL_STOP);
        wait_idle();
        reg_rd(REG_STAT, d);
        check(32'(d[2:0]), 32'h4);
        reg_rd(REG_INT, d);
        check(32'(d[1:0]), 32'h0);
        run(8'h02, 1'b0, 32'h1 << CTRL_START, 1'b1, d);
        check(32'(d[2:0]), 32'h1);
        check(32'(m_reads - rd0), 32'h4);
    endtask
    task automatic t_window();
        logic [31:0] d;
        reg_wr(REG_MASK, 32'h3);
        run(8'h00, 1'b0, 32'h1 << CTRL_PEEK, 1'b1, d);
        check(32'(d[5]), 32'h0);
        repeat (320) @(posedge clk_in);
        run(8'h00, 1'b0, 32'h1 << CTRL_PEEK, 1'b0, d);
        check(32'(d[5]), 32'h1);
        reg_rd(REG_INT, d);
        check(32'(d[2:0]), 32'h4);
        check(32'(irq_out), 32'h0);
        reg_wr(REG_CTRL, 32'h1 << CTRL_RESET);
        wait_idle();
        check(32'(m_resets - rs0), 32'h0);
        run(8'h00, 1'b0, 32'h1 << CTRL_PEEK, 1'b1, d);
        check(32'(d[5]), 32'h0);
    endtask
    initial begin
        repeat (6) @(posedge clk_in);
        reset_in <= 1'b0;
        t_regs();
        t_done();
        t_late();
        t_fail();
        t_stop();
        t_window();
        conclude();
    end
endmodule
